// File: common/sms_pkg.sv
package sms_pkg;
    // ------------------------------------------------------------
    // widths, counts and encodings
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [7:0] HALF_BASE = 8'h02;
    localparam logic [7:0] DIV_ONE = 8'h01;
    localparam logic [1:0] RX_EMPTY = 2'h0;
    localparam logic [1:0] RX_ONE = 2'h1;
    localparam logic [1:0] RX_FULL = 2'h2;
    localparam logic [1:0] RX_STEP = 2'h1;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_LOW = 2'b01,
        M_HIGH = 2'b10
    } sms_mstate_type;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] sms_shift(input logic [7:0] w, input logic b,
                                             input logic lsb_first);
        return lsb_first ? {b, w[DATA_W-1:1]} : {w[DATA_W-2:0], b};
    endfunction : sms_shift

    function automatic logic sms_out_bit(input logic [7:0] w, input logic lsb_first);
        return lsb_first ? w[0] : w[DATA_W-1];
    endfunction : sms_out_bit

    // half period of sck in ref_clk cycles; double speed halves it
    function automatic logic [7:0] sms_half(input logic [1:0] sel, input logic dbl);
        logic [7:0] h;
        h = HALF_BASE << sel;
        return dbl ? (h >> 1) : h;
    endfunction : sms_half
endpackage : sms_pkg

// File: tb/sms_slave_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side slave, mode 0, msb first
// ------------------------------------------------------------
module sms_slave_model
(
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh_q = 8'h00;
    initial rx_byte = 8'h00;
    // deselected line shows the inverse so a stale value never passes
    assign miso = sel_n ? ~sh_q[7] : sh_q[7];
    always @(negedge sel_n) sh_q <= tx_byte;
    always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
    // rotate so a second byte in one frame repeats the first
    always @(negedge sck) if (!sel_n) sh_q <= {sh_q[6:0], sh_q[7]};
endmodule : sms_slave_model

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import sms_pkg::*;
    logic ref_clk = 0, rst = 1, sck_in = 0, enable = 0, cpu_halted = 0, master_wr = 0;
    logic master_wdata = 0, select_pin_disable = 0, ss_is_output = 0, buffer_enable_bit = 0;
    logic buffer_write_select = 0, double_speed_bit = 0, bit_order_select = 0;
    logic transfer_done_irq_enable = 1, transfer_complete_irq_enable = 0, data_wr = 0;
    logic data_rd = 0, done_clr = 0, write_collision_flag_clr = 0, txc_clr = 0, ss_n_in = 1, mosi_in = 0;
    logic miso_dir_out = 1, msel_n = 1;
    logic [1:0] clock_divider_select = 2'h0;
    logic [7:0] data_wdata = 8'h00, tx_m = 8'h00, rx_m, data_rdata, got;
    logic master_bit, transfer_done_flag, write_collision_flag, data_reg_empty_flag;
    logic transfer_complete_flag, irq_req, miso_in, sck_out, mosi_out, miso_out, miso_oe;
    int n_checks = 0, mismatches = 0;

    sms_spi_unit uut (.ref_clk, .rst, .sck_in, .enable, .cpu_halted, .master_wr,
        .master_wdata, .master_bit, .select_pin_disable, .ss_is_output, .buffer_enable_bit,
        .buffer_write_select, .clock_divider_select, .double_speed_bit, .bit_order_select,
        .transfer_done_irq_enable, .transfer_complete_irq_enable, .data_wr, .data_wdata,
        .data_rd, .data_rdata, .done_clr, .write_collision_flag_clr, .txc_clr, .transfer_done_flag,
        .write_collision_flag, .data_reg_empty_flag, .transfer_complete_flag, .irq_req,
        .ss_n_in, .miso_in, .mosi_in, .miso_dir_out, .sck_out, .mosi_out, .miso_out, .miso_oe);
    sms_slave_model far (.sck(sck_out), .mosi(mosi_out), .sel_n(msel_n), .tx_byte(tx_m),
        .miso(miso_in), .rx_byte(rx_m));

    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rev(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction : rev
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wr(input logic [7:0] d);
        @(posedge ref_clk);
        data_wr <= 1'b1;
        data_wdata <= d;
        @(posedge ref_clk);
        data_wr <= 1'b0;
    endtask : wr
    // check the head, then pop it
    task automatic rd(input logic [7:0] exp);
        @(negedge ref_clk);
        chk(data_rdata, exp);
        @(posedge ref_clk);
        data_rd <= 1'b1;
        @(posedge ref_clk);
        data_rd <= 1'b0;
    endtask : rd
    task automatic clr;
        @(posedge ref_clk);
        {done_clr, write_collision_flag_clr, txc_clr} <= 3'h7;
        @(posedge ref_clk);
        {done_clr, write_collision_flag_clr, txc_clr} <= 3'h0;
    endtask : clr
    // bounded wait; a timeout counts as a mismatch
    task automatic wait_flag(input bit txc);
        int n = 0;
        while (((txc ? transfer_complete_flag : transfer_done_flag) !== 1'b1) && n < 600)
        begin
            @(posedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        if (n >= 600) mismatches++;
    endtask : wait_flag
    task automatic sel_far(input logic [7:0] m);
        @(posedge ref_clk);
        tx_m <= m;
        @(posedge ref_clk);
        msel_n <= 1'b0;
    endtask : sel_far
    task automatic xfer(input logic [7:0] d, input logic [7:0] m, input logic lsb, input int h);
        int n = 0;
        bit_order_select <= lsb;
        sel_far(m);
        wr(d);
        while (sck_out !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        n = 0;
        while (sck_out === 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(8'(n), 8'(h));
        wait_flag(1'b0);
        chk(data_rdata, lsb ? rev(m) : m);
        chk(rx_m, lsb ? rev(d) : d);
        chk(8'(irq_req), 8'h01);
        @(posedge ref_clk);
        msel_n <= 1'b1;
        clr();
        @(negedge ref_clk);
        chk(8'(irq_req), 8'h00);
    endtask : xfer
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial
    begin
        #400000;
        mismatches++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        cyc(3);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk({4'h0, master_bit, sck_out, data_reg_empty_flag, transfer_done_flag}, 8'h02);
        chk(data_rdata, 8'h00);
        @(posedge ref_clk);
        master_wr <= 1'b1;
        master_wdata <= 1'b1;
        @(posedge ref_clk);
        master_wr <= 1'b0;
        enable <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            @(posedge ref_clk);
            clock_divider_select <= 2'(s);
            double_speed_bit <= s[0];
            xfer(8'hA5 ^ 8'(s), 8'h3C + 8'(s), s[0], (2 << s) >> s[0]);
        end
        clock_divider_select <= 2'h0;
        double_speed_bit <= 1'b0;
        // the unit is msb first from here on, like the far model
        bit_order_select <= 1'b0;
        // premature write
        sel_far(8'h00);
        wr(8'h11);
        cyc(4);
        wr(8'h22);
        @(negedge ref_clk);
        chk(8'(write_collision_flag), 8'h01);
        chk(8'(data_reg_empty_flag), 8'h01);
        wait_flag(1'b0);
        msel_n <= 1'b1;
        clr();
        // buffer mode, write select must not matter in master
        buffer_enable_bit <= 1'b1;
        buffer_write_select <= 1'b1;
        sel_far(8'h77);
        wr(8'hC3);
        wr(8'h3C);
        @(negedge ref_clk);
        chk(8'(data_reg_empty_flag), 8'h00);
        wr(8'hFF);
        wait_flag(1'b1);
        cyc(2);
        chk(rx_m, 8'h3C);
        rd(8'h77);
        rd(8'h77);
        chk(8'(data_reg_empty_flag), 8'h01);
        msel_n <= 1'b1;
        buffer_enable_bit <= 1'b0;
        clr();
        // debugger halt freezes the clock
        sel_far(8'h00);
        wr(8'h96);
        cyc(6);
        cpu_halted <= 1'b1;
        @(negedge ref_clk);
        got = {7'h0, sck_out};
        repeat (20) @(negedge ref_clk) if (sck_out !== got[0]) got = 8'hEE;
        chk({1'b0, got[7:1]}, 8'h00);
        @(posedge ref_clk);
        cpu_halted <= 1'b0;
        wait_flag(1'b0);
        chk(rx_m, 8'h96);
        msel_n <= 1'b1;
        clr();
        // select pin in master mode: input, disabled, output
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            select_pin_disable <= (k == 1);
            ss_is_output <= (k == 2);
            ss_n_in <= 1'b0;
            cyc(6);
            @(negedge ref_clk);
            chk(8'(master_bit), 8'(k != 0));
            chk(8'(transfer_done_flag), 8'(k == 0));
            @(posedge ref_clk);
            ss_n_in <= 1'b1;
            cyc(4);
            @(negedge ref_clk);
            chk(8'(master_bit), 8'(k != 0));
            // software sets the role again; the last pass leaves a slave
            @(posedge ref_clk);
            master_wdata <= (k != 2);
            master_wr <= 1'b1;
            @(posedge ref_clk);
            master_wr <= 1'b0;
            clr();
        end
        // slave mode, link clock from the bench
        select_pin_disable <= 1'b0;
        ss_is_output <= 1'b0;
        @(negedge ref_clk);
        chk(8'(miso_oe), 8'h00);
        wr(8'h5A);
        ss_n_in <= 1'b0;
        cyc(4);
        #7;
        chk(8'(miso_oe), 8'h01);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_in = 1'(8'hA6 >> i);
            #40;
            got[i] = miso_out;
            sck_in = 1'b1;
            #40;
            sck_in = 1'b0;
        end
        chk(got, 8'h5A);
        cyc(8);
        ss_n_in <= 1'b1;
        cyc(4);
        @(negedge ref_clk);
        chk(8'(miso_oe), 8'h00);
        chk(8'(transfer_done_flag), 8'h01);
        chk(data_rdata, 8'hA6);
        give_verdict();
    end
endmodule : tb

// File: verilog/sms_spi_unit.sv
`timescale 1ns/100ps
// Operation
// - master data write starts clocking out eight bits, then sets done flag
// - master, select enabled, pin input: low select drops master bit to slave
// - that forced drop also sets done flag and may request interrupt
// - select disable set: select pin ignored in master mode
// - select pin configured output: its level never affects master
// - normal mode write during transfer sets collision flag; only a master write corrupts data
// - normal mode received byte lands in first receive buffer at completion
// - normal mode data read returns first buffer; unread byte is overwritten
// - normal mode leaves transmit buffer and second receive buffer unused
// - normal completion sets done flag; interrupt when its enable is set
// - buffer enable selects buffer mode; write select ignored in master
// - buffer mode: writes taken while empty flag set; first direct, next buffered
// - buffer mode: received bytes enter two entry fifo read via data port
// - buffer mode: complete flag when shifter and transmit buffer empty
// - slave offers unbuffered and two buffered variants, clocked by master
// - master engine freezes while cpu is halted by debugger
// - data write loads shifter in normal mode unless slave selected; buffer mode: shifter if master idle or slave deselected with write select, else tx buffer
// - slave drives miso only while select low and miso set as output
module sms_spi_unit
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck_in,
    input wire logic enable,
    input wire logic cpu_halted,
    input wire logic master_wr,
    input wire logic master_wdata,
    output logic master_bit,
    input wire logic select_pin_disable,
    input wire logic ss_is_output,
    input wire logic buffer_enable_bit,
    input wire logic buffer_write_select,
    input wire logic [1:0] clock_divider_select,
    input wire logic double_speed_bit,
    input wire logic bit_order_select,
    input wire logic transfer_done_irq_enable,
    input wire logic transfer_complete_irq_enable,
    input wire logic data_wr,
    input wire logic [sms_pkg::DATA_W-1:0] data_wdata,
    input wire logic data_rd,
    output logic [sms_pkg::DATA_W-1:0] data_rdata,
    input wire logic done_clr,
    input wire logic write_collision_flag_clr,
    input wire logic txc_clr,
    output logic transfer_done_flag,
    output logic write_collision_flag,
    output logic data_reg_empty_flag,
    output logic transfer_complete_flag,
    output logic irq_req,
    input wire logic ss_n_in,
    input wire logic miso_in,
    input wire logic mosi_in,
    input wire logic miso_dir_out,
    output logic sck_out,
    output logic mosi_out,
    output logic miso_out,
    output logic miso_oe
);
    import sms_pkg::*;

    logic master_q;
    sms_mstate_type mst_q;
    logic [2:0] bit_q;
    logic [7:0] div_q;
    logic sck_q;
    logic [7:0] sh_q;
    logic [7:0] txbuf_q;
    logic txbuf_v_q;
    logic [7:0] rx1_q;
    logic [7:0] rx2_q;
    logic [1:0] rx_cnt_q;
    logic done_q;
    logic write_collision_flag_q;
    logic txc_q;
    logic ss_s1_q, ss_s2_q;
    logic miso_s1_q, miso_s2_q;
    logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
    logic [7:0] s_sh_q;
    logic [2:0] s_cnt_q;
    logic [7:0] s_rx_q;
    logic s_tgl_q;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else
        begin
            ss_s1_q <= ss_n_in;
            ss_s2_q <= ss_s1_q;
            miso_s1_q <= miso_in;
            miso_s2_q <= miso_s1_q;
        end
    end

    // completion event from the sck domain arrives as a toggle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end
        else
        begin
            tgl_s1_q <= s_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic m_act, buf_mode, m_busy, m_tick, m_shift, m_done;
    logic ss_force, s_done, wr_direct, wr_buf, wr_col, reload, push, pop;
    logic [7:0] rx_byte;

    assign buf_mode = buffer_enable_bit;
    assign m_act = enable && master_q;
    assign m_busy = (mst_q != M_IDLE);
    assign m_tick = (div_q == DIV_ONE) && !cpu_halted;
    // shifting on the fall keeps mosi steady across each rise
    assign m_shift = m_act && (mst_q == M_HIGH) && m_tick;
    assign m_done = m_act && (mst_q == M_HIGH) && m_tick && (bit_q == LAST_BIT);
    // ssd set or pin as output leave the master untouched
    assign ss_force = m_act && !select_pin_disable && !ss_is_output && !ss_s2_q;
    assign s_done = enable && !master_q && (tgl_s2_q ^ tgl_s3_q);
    assign push = m_done || s_done;
    // the last miso bit enters on the completing edge itself
    assign rx_byte = master_q ? sms_shift(sh_q, miso_s2_q, bit_order_select) : s_rx_q;
    assign pop = data_rd && buf_mode && (rx_cnt_q != RX_EMPTY);
    assign reload = buf_mode && txbuf_v_q && push;

    // write steering: master normal lands in the shifter even mid transfer, unless a shift falls in that cycle
    always_comb
    begin
        wr_direct = 1'b0;
        wr_buf = 1'b0;
        wr_col = 1'b0;
        if (data_wr && enable)
        begin
            if (!buf_mode)
            begin
                if (master_q)
                begin
                    wr_direct = 1'b1;
                    wr_col = m_busy;
                end
                else
                begin
                    // a selected slave ignores the premature write
                    wr_direct = ss_s2_q;
                    wr_col = !ss_s2_q;
                end
            end
            else if (!txbuf_v_q)
            begin
                if (master_q ? !m_busy : (buffer_write_select && ss_s2_q))
                    wr_direct = 1'b1;
                else
                    wr_buf = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // master role bit
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            master_q <= 1'b0;
        else if (master_wr)
            master_q <= master_wdata;
        else if (ss_force)
            master_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // master clock engine, sck low idle, shift on fall
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst || ss_force || !m_act)
        begin
            mst_q <= M_IDLE;
            bit_q <= FIRST_BIT;
            div_q <= DIV_ONE;
            sck_q <= 1'b0;
        end
        else if ((!m_busy && wr_direct) || reload)
        begin
            mst_q <= M_LOW;
            bit_q <= FIRST_BIT;
            div_q <= sms_half(clock_divider_select, double_speed_bit);
            sck_q <= 1'b0;
        end
        else if (!cpu_halted)
        begin
            unique case (mst_q)
                M_IDLE:
                begin
                    sck_q <= 1'b0;
                end
                M_LOW:
                begin
                    if (m_tick)
                    begin
                        mst_q <= M_HIGH;
                        sck_q <= 1'b1;
                        div_q <= sms_half(clock_divider_select, double_speed_bit);
                    end
                    else
                        div_q <= div_q - DIV_ONE;
                end
                M_HIGH:
                begin
                    if (m_tick)
                    begin
                        sck_q <= 1'b0;
                        div_q <= sms_half(clock_divider_select, double_speed_bit);
                        bit_q <= bit_q + BIT_STEP;
                        mst_q <= (bit_q == LAST_BIT) ? M_IDLE : M_LOW;
                    end
                    else
                        div_q <= div_q - DIV_ONE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shifter and transmit buffer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sh_q <= '0;
        else if (reload)
            sh_q <= txbuf_q;
        // miso passes two flops, so a one cycle half period reads a stale bit
        else if (m_shift)
            sh_q <= sms_shift(sh_q, miso_s2_q, bit_order_select);
        else if (wr_direct)
            sh_q <= data_wdata;
    end

    // normal mode never touches the transmit buffer
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            txbuf_q <= '0;
            txbuf_v_q <= 1'b0;
        end
        else if (wr_buf)
        begin
            txbuf_q <= data_wdata;
            txbuf_v_q <= 1'b1;
        end
        else if (reload)
            txbuf_v_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // receive side: single buffer or two entry fifo
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rx1_q <= '0;
            rx2_q <= '0;
            rx_cnt_q <= RX_EMPTY;
        end
        else if (!buf_mode)
        begin
            if (push)
                rx1_q <= rx_byte;
        end
        else if (push && pop)
        begin
            if (rx_cnt_q == RX_ONE)
                rx1_q <= rx_byte;
            else
            begin
                rx1_q <= rx2_q;
                rx2_q <= rx_byte;
            end
        end
        else if (push)
        begin
            // a third unread byte is dropped
            if (rx_cnt_q == RX_EMPTY)
                rx1_q <= rx_byte;
            else if (rx_cnt_q == RX_ONE)
                rx2_q <= rx_byte;
            if (rx_cnt_q != RX_FULL)
                rx_cnt_q <= rx_cnt_q + RX_STEP;
        end
        else if (pop)
        begin
            rx1_q <= rx2_q;
            rx_cnt_q <= rx_cnt_q - RX_STEP;
        end
    end

    // ------------------------------------------------------------
    // flags, a set beats a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            done_q <= 1'b0;
        else if (push || ss_force)
            done_q <= 1'b1;
        else if (done_clr)
            done_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            write_collision_flag_q <= 1'b0;
        else if (wr_col)
            write_collision_flag_q <= 1'b1;
        else if (write_collision_flag_clr)
            write_collision_flag_q <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            txc_q <= 1'b0;
        else if (buf_mode && push && !txbuf_v_q)
            txc_q <= 1'b1;
        else if (txc_clr)
            txc_q <= 1'b0;
    end

    assign irq_req = (done_q && transfer_done_irq_enable)
        || (txc_q && transfer_complete_irq_enable);

    // ------------------------------------------------------------
    // slave shifter on the master's clock
    // ------------------------------------------------------------
    // the tx word is read at the first edge; software loads it while deselected
    always_ff @(posedge sck_in or posedge ss_n_in)
    begin
        if (ss_n_in)
        begin
            s_cnt_q <= FIRST_BIT;
            s_sh_q <= '0;
        end
        else
        begin
            s_cnt_q <= s_cnt_q + BIT_STEP;
            s_sh_q <= sms_shift((s_cnt_q == FIRST_BIT) ? sh_q : s_sh_q, mosi_in,
                                bit_order_select);
        end
    end

    always_ff @(posedge sck_in or posedge rst)
    begin
        if (rst)
        begin
            s_tgl_q <= 1'b0;
            s_rx_q <= '0;
        end
        else if (!ss_n_in && s_cnt_q == LAST_BIT)
        begin
            s_tgl_q <= ~s_tgl_q;
            s_rx_q <= sms_shift(s_sh_q, mosi_in, bit_order_select);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign master_bit = master_q;
    assign data_rdata = rx1_q;
    assign transfer_done_flag = done_q;
    assign write_collision_flag = write_collision_flag_q;
    assign data_reg_empty_flag = !txbuf_v_q;
    assign transfer_complete_flag = txc_q;
    assign sck_out = sck_q;
    assign mosi_out = sms_out_bit(sh_q, bit_order_select);
    assign miso_out = sms_out_bit((s_cnt_q == FIRST_BIT) ? sh_q : s_sh_q, bit_order_select);
    assign miso_oe = enable && !master_q && miso_dir_out && !ss_n_in;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_start_xfer: assert property (m_act && !m_busy && wr_direct && !ss_force
        |=> mst_q == M_LOW) else $error("write did not start transfer");
    a_xfer_ends: assert property ($rose(m_busy) |-> ##[15:520] (m_done or !m_act))
        else $error("transfer never completed");
    a_mode_drop: assert property (ss_force && !master_wr |=> !master_q && done_q)
        else $error("low select did not force slave");
    a_ssd_ignore: assert property (m_act && select_pin_disable && !master_wr
        |=> master_q) else $error("select pin acted with disable set");
    a_ss_output: assert property (m_act && ss_is_output && !master_wr |=> master_q)
        else $error("output select pin acted");
    a_write_collision_flag_set: assert property (wr_col |=> write_collision_flag)
        else $error("collision flag missing");
    a_normal_rx: assert property (!buf_mode && m_done |=> data_rdata == sh_q)
        else $error("byte not in first buffer");
    a_txc_set: assert property (buf_mode && push && !txbuf_v_q |=> transfer_complete_flag)
        else $error("complete flag missing");
    a_halt_freeze: assert property (cpu_halted && m_act && !ss_force && !wr_direct
        && !reload |=> $stable(div_q) && $stable(bit_q)) else $error("ran while halted");
    a_miso_oe: assert property (miso_oe |-> !master_q && !ss_n_in)
        else $error("miso driven while deselected");

    c_master_done: cover property (m_done);
    c_mode_drop: cover property (ss_force);
    c_buf_reload: cover property (reload ##[1:300] m_done);
    c_slave_done: cover property (s_done);
endmodule : sms_spi_unit
